/* hdl/status_bank_pkg.sv */
// constants and types of the port power status register bank
package status_bank_pkg;
   // ==========================================
   // register offsets
   localparam logic [7:0] OFF_MISC = 8'h0f;
   localparam logic [7:0] OFF_FAULT = 8'h10;
   localparam logic [7:0] OFF_EVENT = 8'h11;
   localparam logic [7:0] OFF_PROF_PRI = 8'h12;
   localparam logic [7:0] OFF_PROF_LEG = 8'h13;
   localparam logic [7:0] OFF_LINES = 8'h14;
   // ==========================================
   // reset values
   localparam logic [7:0] RST_FAULT = 8'h20;
   localparam logic [7:0] RST_EVENT = 8'h00;
   localparam logic [7:0] RST_PROF = 8'h00;
   localparam logic [7:0] RST_RDATA = 8'h00;
   // ==========================================
   // fault register fields
   localparam int B_ERR = 7;
   localparam int B_RESET_IND = 5;
   localparam logic [7:0] FAULT_COND_MASK = 8'h5f;
   localparam logic [7:0] FAULT_OTHER_MASK = 8'h7f;
   // event register fields
   localparam int B_QUOTA = 7;
   localparam int B_CLAMP = 4;
   localparam int B_THROTTLE = 3;
   localparam int B_SMALL = 2;
   localparam int B_GONE = 1;
   localparam int B_NEW = 0;
   // ==========================================
   // synchronised input positions
   localparam int SYNC_W = 16;
   localparam int S_COND0 = 0;
   localparam int S_DRAW = 6;
   localparam int S_CLAMP = 7;
   localparam int S_THROTTLE = 8;
   localparam int S_SMALL = 9;
   localparam int S_ALERT_IN = 10;
   localparam int S_DET_IN = 11;
   localparam int S_PINS0 = 12;
   // ==========================================
   // power state codes
   localparam logic [1:0] CODE_SLEEP = 2'h0;
   localparam logic [1:0] CODE_DETECT = 2'h1;
   localparam logic [1:0] CODE_ACTIVE = 2'h2;
   localparam logic [1:0] CODE_ERROR = 2'h3;
   typedef enum logic [3:0] {
      ST_SLEEP = 4'h1,
      ST_DETECT = 4'h2,
      ST_ACTIVE = 4'h4,
      ST_ERROR = 4'h8
   } pstate_t;
endpackage

/* hdl/sync_if.sv */
// carrier for raw and synchronised outside levels
`timescale 1ns/1ns
interface sync_if #(parameter int W = 16);
   logic [W-1:0] raw;
   logic [W-1:0] sync;
   modport src (output raw, input sync);
   modport snk (input raw, output sync);
endinterface

/* hdl/line_sync.sv */
// two flip-flop synchroniser for outside levels
`timescale 1ns/1ns
module line_sync #(parameter int W = 16)
(
   input wire logic clk,
   input wire logic rst_n,
   sync_if.snk lines
);
   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } sync_state_t;

   sync_state_t st_reg;
   sync_state_t st_next;

   always_comb
   begin
      st_next.stage1 = lines.raw;
      st_next.stage2 = st_reg.stage1;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign lines.sync = st_reg.stage2;
endmodule

/* hdl/status_bank.sv */
// status register bank of the port power controller
`timescale 1ns/1ns
// Operation
// - mirror bits show fault and presence lines low
// - draw flag follows current above charge threshold
// - emulation flag only while Active and emulating
// - handshake step field codes applied pair
// - entering Error with switch on sets the error flag
// - writing zero clears error, recheck, maybe Active
// - other fault bits set keep Error state
// - auto-recovery or switch off clears error flag
// - fault line independent of error flag
// - six latched fault flags
// - fault flags assert fault line, force Error
// - read clears gone fault; error clear clears all
// - reset flag at power up, clear read/toggle
// - quota flag, optional alert, three clears
// - clamp flag shows current over limit
// - throttle flag, read clear, alert if linked
// - small draw flag, read clear, alert if linked
// - removal sets gone flag, releases presence
// - attach sets new flag, asserts presence
// - profile bits clear on off/mode/removal
// - power state code, never Sleep on read
module status_bank
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic RD_EN,
   input wire logic WR_EN,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   output logic [7:0] RDATA,
   input wire logic [5:0] FAULT_COND,
   input wire logic DRAW_ABOVE,
   input wire logic CLAMP_COND,
   input wire logic THROTTLE_COND,
   input wire logic SMALL_COND,
   input wire logic [3:0] PIN_LEVELS,
   input wire logic ALERT_IN,
   output logic ALERT_OUT,
   output logic ALERT_OE,
   input wire logic DET_IN,
   output logic DET_OUT,
   output logic DET_OE,
   input wire logic SWITCH_ENABLE,
   input wire logic AUTO_RECOVERY,
   input wire logic ALERT_LINK,
   input wire logic QUOTA_MET,
   input wire logic QUOTA_ACTION_SELECT,
   input wire logic QUOTA_RESTART,
   input wire logic QUOTA_ENABLE,
   input wire logic ATTACH_EVT,
   input wire logic REMOVAL_EVT,
   input wire logic SLEEP_REQ,
   input wire logic EMU_APPLYING,
   input wire logic [1:0] HANDSHAKE_STEP,
   input wire logic [3:0] APPLIED_PROFILE_CODE,
   input wire logic NEW_MODE,
   input wire logic [4:0] PROF_PRI_SET,
   input wire logic NO_HANDSHAKE,
   input wire logic VS_LOW,
   input wire logic [6:0] PROF_LEG_SET,
   output logic [1:0] POWER_STATE_CODE
);
   typedef struct packed {
      status_bank_pkg::pstate_t pstate;
      logic [7:0] fault;
      logic [7:0] events;
      logic [3:0] prof_pri;
      logic [6:0] prof_leg;
      logic [7:0] rdata;
      logic alert_oe;
      logic det_oe;
      logic sw_en_d;
      logic [1:0] code;
   } bank_state_t;

   bank_state_t st_reg;
   bank_state_t st_next;
   logic [status_bank_pkg::SYNC_W-1:0] synced;
   logic [5:0] cond;
   logic any_cond;
   logic rd_fault;
   logic rd_event;
   logic err_wr_clear;
   logic err_clear;
   logic prof_clear;
   logic [1:0] state_code;
   logic [7:0] mux;

   // ==========================================
   // outside level synchronisers
   sync_if #(.W(status_bank_pkg::SYNC_W)) lines ();

   assign lines.raw = {PIN_LEVELS, DET_IN, ALERT_IN, SMALL_COND, THROTTLE_COND,
                       CLAMP_COND, DRAW_ABOVE, FAULT_COND};
   assign synced = lines.sync;

   line_sync #(.W(status_bank_pkg::SYNC_W)) u_sync
   (
      .clk(CLK),
      .rst_n(RST_N),
      .lines(lines)
   );

   // ==========================================
   // decodes
   always_comb
   begin
      cond = synced[status_bank_pkg::S_COND0 +: 6];
      any_cond = |cond;
      rd_fault = RD_EN && (ADDR == status_bank_pkg::OFF_FAULT);
      rd_event = RD_EN && (ADDR == status_bank_pkg::OFF_EVENT);
      err_wr_clear = WR_EN && (ADDR == status_bank_pkg::OFF_FAULT) &&
                     !WDATA[status_bank_pkg::B_ERR];
      prof_clear = !SWITCH_ENABLE || NEW_MODE || REMOVAL_EVT;
      case (st_reg.pstate)
         status_bank_pkg::ST_SLEEP: state_code = status_bank_pkg::CODE_SLEEP;
         status_bank_pkg::ST_DETECT: state_code = status_bank_pkg::CODE_DETECT;
         status_bank_pkg::ST_ACTIVE: state_code = status_bank_pkg::CODE_ACTIVE;
         status_bank_pkg::ST_ERROR: state_code = status_bank_pkg::CODE_ERROR;
         default: state_code = status_bank_pkg::CODE_DETECT;
      endcase
   end

   // ==========================================
   // read data selection
   always_comb
   begin
      case (ADDR)
         status_bank_pkg::OFF_MISC:
         begin
            mux = 8'h00;
            mux[5] = !synced[status_bank_pkg::S_ALERT_IN];
            mux[4] = !synced[status_bank_pkg::S_DET_IN];
            mux[3] = synced[status_bank_pkg::S_DRAW];
            if (EMU_APPLYING && (st_reg.pstate == status_bank_pkg::ST_ACTIVE))
            begin
               mux[2] = 1'b1;
               mux[1:0] = HANDSHAKE_STEP;
            end
         end
         status_bank_pkg::OFF_FAULT: mux = st_reg.fault;
         status_bank_pkg::OFF_EVENT: mux = st_reg.events;
         status_bank_pkg::OFF_PROF_PRI:
            mux = {NO_HANDSHAKE, 2'h0, VS_LOW, st_reg.prof_pri};
         status_bank_pkg::OFF_PROF_LEG: mux = {1'b0, st_reg.prof_leg};
         status_bank_pkg::OFF_LINES:
         begin
            mux = {1'b0, SWITCH_ENABLE, synced[status_bank_pkg::S_PINS0 +: 4], state_code};
            if (state_code == status_bank_pkg::CODE_SLEEP)
            begin
               mux[1:0] = status_bank_pkg::CODE_DETECT;
            end
         end
         default: mux = 8'h00;
      endcase
   end

   // ==========================================
   // next state
   always_comb
   begin
      st_next = st_reg;
      st_next.sw_en_d = SWITCH_ENABLE;
      if (RD_EN)
      begin
         st_next.rdata = mux;
      end

      // error flag clearing sources
      err_clear = st_reg.fault[status_bank_pkg::B_ERR] &&
                  (err_wr_clear || (AUTO_RECOVERY && !any_cond));
      if (!SWITCH_ENABLE)
      begin
         err_clear = st_reg.fault[status_bank_pkg::B_ERR];
      end

      // latched fault flags
      for (int i = 0; i < 5; i++)
      begin
         if ((rd_fault && !cond[i]) || err_clear)
         begin
            st_next.fault[i] = 1'b0;
         end
         if (cond[i])
         begin
            st_next.fault[i] = 1'b1;
         end
      end
      if ((rd_fault && !cond[5]) || err_clear)
      begin
         st_next.fault[6] = 1'b0;
      end
      if (cond[5])
      begin
         st_next.fault[6] = 1'b1;
      end
      if (rd_fault || (SWITCH_ENABLE != st_reg.sw_en_d))
      begin
         st_next.fault[status_bank_pkg::B_RESET_IND] = 1'b0;
      end
      if (err_clear)
      begin
         st_next.fault[status_bank_pkg::B_ERR] = 1'b0;
      end

      // power state
      case (st_reg.pstate)
         status_bank_pkg::ST_SLEEP:
         begin
            if (RD_EN || WR_EN || !SLEEP_REQ)
            begin
               st_next.pstate = status_bank_pkg::ST_DETECT;
            end
         end
         status_bank_pkg::ST_DETECT:
         begin
            if (SWITCH_ENABLE)
            begin
               st_next.pstate = status_bank_pkg::ST_ACTIVE;
            end
            else if (SLEEP_REQ && !RD_EN && !WR_EN)
            begin
               st_next.pstate = status_bank_pkg::ST_SLEEP;
            end
         end
         status_bank_pkg::ST_ACTIVE:
         begin
            if (!SWITCH_ENABLE)
            begin
               st_next.pstate = status_bank_pkg::ST_DETECT;
            end
         end
         status_bank_pkg::ST_ERROR:
         begin
            if (!st_next.fault[status_bank_pkg::B_ERR] &&
                !(|(st_next.fault & status_bank_pkg::FAULT_OTHER_MASK)))
            begin
               st_next.pstate = SWITCH_ENABLE ? status_bank_pkg::ST_ACTIVE :
                                status_bank_pkg::ST_DETECT;
            end
         end
         default: st_next.pstate = status_bank_pkg::ST_DETECT;
      endcase
      if (|(st_next.fault & status_bank_pkg::FAULT_COND_MASK))
      begin
         st_next.pstate = status_bank_pkg::ST_ERROR;
      end
      if ((st_next.pstate == status_bank_pkg::ST_ERROR) && SWITCH_ENABLE &&
          ((st_reg.pstate != status_bank_pkg::ST_ERROR) || any_cond))
      begin
         st_next.fault[status_bank_pkg::B_ERR] = 1'b1;
      end

      // event flags
      if (rd_event || QUOTA_RESTART || !QUOTA_ENABLE)
      begin
         st_next.events[status_bank_pkg::B_QUOTA] = 1'b0;
      end
      if (QUOTA_MET)
      begin
         st_next.events[status_bank_pkg::B_QUOTA] = 1'b1;
      end
      st_next.events[status_bank_pkg::B_CLAMP] = synced[status_bank_pkg::S_CLAMP];
      if (rd_event)
      begin
         st_next.events[3:0] = 4'h0;
      end
      if (synced[status_bank_pkg::S_THROTTLE])
      begin
         st_next.events[status_bank_pkg::B_THROTTLE] = 1'b1;
      end
      if (synced[status_bank_pkg::S_SMALL])
      begin
         st_next.events[status_bank_pkg::B_SMALL] = 1'b1;
      end
      if (REMOVAL_EVT)
      begin
         st_next.events[status_bank_pkg::B_GONE] = 1'b1;
         st_next.det_oe = 1'b0;
      end
      if (ATTACH_EVT)
      begin
         st_next.events[status_bank_pkg::B_NEW] = 1'b1;
         st_next.det_oe = 1'b1;
      end

      // profile acceptance indicators
      if (prof_clear)
      begin
         st_next.prof_pri = 4'h0;
         st_next.prof_leg = 7'h00;
      end
      st_next.prof_pri = st_next.prof_pri | PROF_PRI_SET[3:0];
      st_next.prof_leg = st_next.prof_leg | PROF_LEG_SET;

      // fault line, not tied to the error flag
      st_next.alert_oe = (|(st_next.fault & status_bank_pkg::FAULT_COND_MASK)) ||
         (st_next.events[status_bank_pkg::B_QUOTA] && QUOTA_ACTION_SELECT) ||
         (ALERT_LINK && (st_next.events[status_bank_pkg::B_THROTTLE] ||
                         st_next.events[status_bank_pkg::B_SMALL]));
      // registered power state code
      st_next.code = {st_next.pstate[3] | st_next.pstate[2],
                      st_next.pstate[3] | st_next.pstate[1]};
   end

   // ==========================================
   // state register
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         st_reg.pstate <= status_bank_pkg::ST_DETECT;
         st_reg.fault <= status_bank_pkg::RST_FAULT;
         st_reg.events <= status_bank_pkg::RST_EVENT;
         st_reg.prof_pri <= 4'h0;
         st_reg.prof_leg <= 7'h00;
         st_reg.rdata <= status_bank_pkg::RST_RDATA;
         st_reg.alert_oe <= 1'b0;
         st_reg.det_oe <= 1'b0;
         st_reg.sw_en_d <= SWITCH_ENABLE;
         st_reg.code <= status_bank_pkg::CODE_DETECT;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign RDATA = st_reg.rdata;
   assign ALERT_OUT = 1'b0;
   assign ALERT_OE = st_reg.alert_oe;
   assign DET_OUT = 1'b0;
   assign DET_OE = st_reg.det_oe;
   assign POWER_STATE_CODE = st_reg.code;

   // ==========================================
   // checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   property p_err_on_entry;
      $rose(st_reg.pstate == status_bank_pkg::ST_ERROR) && $past(SWITCH_ENABLE)
         |-> st_reg.fault[7];
   endproperty
   a_err_on_entry: assert property (p_err_on_entry) else $error("error flag not set");

   property p_fault_alert;
      (|(st_reg.fault & status_bank_pkg::FAULT_COND_MASK)) |-> ALERT_OE &&
         (st_reg.pstate == status_bank_pkg::ST_ERROR);
   endproperty
   a_fault_alert: assert property (p_fault_alert) else $error("fault flag without alert");

   property p_stay_error;
      (st_reg.pstate == status_bank_pkg::ST_ERROR)
         |=> (st_reg.pstate == status_bank_pkg::ST_ERROR) || !(|st_reg.fault[6:0]);
   endproperty
   a_stay_error: assert property (p_stay_error) else $error("left error early");

   property p_switch_off;
      !SWITCH_ENABLE |=> !st_reg.fault[7];
   endproperty
   a_switch_off: assert property (p_switch_off) else $error("error flag kept");

   property p_attach;
      ATTACH_EVT |=> DET_OE && st_reg.events[0];
   endproperty
   a_attach: assert property (p_attach) else $error("attach lost");

   property p_removal;
      REMOVAL_EVT && !ATTACH_EVT |=> !DET_OE && st_reg.events[1];
   endproperty
   a_removal: assert property (p_removal) else $error("removal lost");

   property p_read_keeps;
      rd_event && ATTACH_EVT |=> st_reg.events[0] ##1 1'b1;
   endproperty
   a_read_keeps: assert property (p_read_keeps) else $error("event lost on read");

   property p_quota_restart;
      QUOTA_RESTART && !QUOTA_MET |=> !st_reg.events[7];
   endproperty
   a_quota_restart: assert property (p_quota_restart) else $error("quota kept");

   property p_no_sleep_read;
      RD_EN && (ADDR == status_bank_pkg::OFF_LINES) |=> RDATA[1:0] != 2'h0;
   endproperty
   a_no_sleep_read: assert property (p_no_sleep_read) else $error("sleep code read");

   property p_toggle_reset;
      $changed(SWITCH_ENABLE) |=> ##1 !st_reg.fault[5];
   endproperty
   a_toggle_reset: assert property (p_toggle_reset) else $error("reset flag kept");
endmodule

/* bench/line_model.sv */
// pulled-up wired fault and presence lines seen by the host side
`timescale 1ns/1ns
module line_model
(
   input wire logic alert_oe,
   input wire logic alert_out,
   input wire logic det_oe,
   input wire logic det_out,
   input wire logic ext_alert_low,
   input wire logic ext_det_low,
   output logic alert_line,
   output logic det_line
);
   // ==========================================
   // wired lines: pull-up unless any party pulls low
   assign alert_line = ((alert_oe && !alert_out) || ext_alert_low) ? 1'b0 : 1'b1;
   assign det_line = ((det_oe && !det_out) || ext_det_low) ? 1'b0 : 1'b1;
endmodule

/* bench/tb.sv */
// self-checking bench of the status register bank
`timescale 1ns/1ns
module tb;
   localparam logic [7:0] A_MISC = status_bank_pkg::OFF_MISC;
   localparam logic [7:0] A_FLT = status_bank_pkg::OFF_FAULT;
   localparam logic [7:0] A_EVT = status_bank_pkg::OFF_EVENT;
   localparam logic [7:0] A_PRI = status_bank_pkg::OFF_PROF_PRI;
   localparam logic [7:0] A_LEG = status_bank_pkg::OFF_PROF_LEG;
   localparam logic [7:0] A_PIN = status_bank_pkg::OFF_LINES;
   logic CLK, RST_N, RD_EN, WR_EN;
   logic [7:0] ADDR, WDATA, RDATA, d;
   logic [5:0] FAULT_COND;
   logic DRAW_ABOVE, CLAMP_COND, THROTTLE_COND, SMALL_COND;
   logic [3:0] PIN_LEVELS, APPLIED_PROFILE_CODE;
   logic ALERT_IN, ALERT_OUT, ALERT_OE, DET_IN, DET_OUT, DET_OE;
   logic SWITCH_ENABLE, AUTO_RECOVERY, ALERT_LINK, QUOTA_MET, QUOTA_ACTION_SELECT;
   logic QUOTA_RESTART, QUOTA_ENABLE, ATTACH_EVT, REMOVAL_EVT, SLEEP_REQ;
   logic EMU_APPLYING, NEW_MODE, NO_HANDSHAKE, VS_LOW, ext_alert_low, ext_det_low;
   logic [1:0] HANDSHAKE_STEP, POWER_STATE_CODE;
   logic [4:0] PROF_PRI_SET;
   logic [6:0] PROF_LEG_SET;
   logic [7:0] fmap [6];
   int errors;
   int n_tests;
   // ==========================================
   // design and wired lines
   status_bank u_status_bank (.CLK(CLK), .RST_N(RST_N), .RD_EN(RD_EN), .WR_EN(WR_EN),
      .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA), .FAULT_COND(FAULT_COND),
      .DRAW_ABOVE(DRAW_ABOVE), .CLAMP_COND(CLAMP_COND), .THROTTLE_COND(THROTTLE_COND),
      .SMALL_COND(SMALL_COND), .PIN_LEVELS(PIN_LEVELS), .ALERT_IN(ALERT_IN),
      .ALERT_OUT(ALERT_OUT), .ALERT_OE(ALERT_OE), .DET_IN(DET_IN), .DET_OUT(DET_OUT),
      .DET_OE(DET_OE), .SWITCH_ENABLE(SWITCH_ENABLE), .AUTO_RECOVERY(AUTO_RECOVERY),
      .ALERT_LINK(ALERT_LINK), .QUOTA_MET(QUOTA_MET),
      .QUOTA_ACTION_SELECT(QUOTA_ACTION_SELECT), .QUOTA_RESTART(QUOTA_RESTART),
      .QUOTA_ENABLE(QUOTA_ENABLE), .ATTACH_EVT(ATTACH_EVT), .REMOVAL_EVT(REMOVAL_EVT),
      .SLEEP_REQ(SLEEP_REQ), .EMU_APPLYING(EMU_APPLYING), .HANDSHAKE_STEP(HANDSHAKE_STEP),
      .APPLIED_PROFILE_CODE(APPLIED_PROFILE_CODE), .NEW_MODE(NEW_MODE),
      .PROF_PRI_SET(PROF_PRI_SET), .NO_HANDSHAKE(NO_HANDSHAKE), .VS_LOW(VS_LOW),
      .PROF_LEG_SET(PROF_LEG_SET), .POWER_STATE_CODE(POWER_STATE_CODE));
   line_model u_line_model (.alert_oe(ALERT_OE), .alert_out(ALERT_OUT), .det_oe(DET_OE),
      .det_out(DET_OUT), .ext_alert_low(ext_alert_low), .ext_det_low(ext_det_low),
      .alert_line(ALERT_IN), .det_line(DET_IN));
   // ==========================================
   // tasks
   task automatic tick(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge CLK);
      RD_EN <= 1'b1;
      ADDR <= a;
      @(posedge CLK);
      RD_EN <= 1'b0;
      tick(1);
      v = RDATA;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge CLK);
      WR_EN <= 1'b1;
      ADDR <= a;
      WDATA <= v;
      @(posedge CLK);
      WR_EN <= 1'b0;
   endtask
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic check1(input logic got, input logic exp);
      check8({7'h0, got}, {7'h0, exp});
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      logic [7:0] v;
      rd(a, v);
      check8(v & m, e & m);
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ==========================================
   // clock and watchdog
   initial
   begin
      CLK = 1'b0;
      forever #50 CLK = ~CLK;
   end
   initial
   begin
      #3000000;
      errors++;
      summarize();
   end
   // ==========================================
   // tests
   initial
   begin
      errors = 0;
      n_tests = 0;
      fmap = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h40};
      {RST_N, RD_EN, WR_EN, ADDR, WDATA, FAULT_COND, DRAW_ABOVE, CLAMP_COND} = '0;
      {THROTTLE_COND, SMALL_COND, AUTO_RECOVERY, ALERT_LINK, QUOTA_MET} = '0;
      {QUOTA_ACTION_SELECT, QUOTA_RESTART, QUOTA_ENABLE, ATTACH_EVT, REMOVAL_EVT} = '0;
      {SLEEP_REQ, EMU_APPLYING, HANDSHAKE_STEP, APPLIED_PROFILE_CODE, NEW_MODE} = '0;
      {PROF_PRI_SET, PROF_LEG_SET, NO_HANDSHAKE, VS_LOW, ext_alert_low, ext_det_low} = '0;
      PIN_LEVELS = 4'ha;
      SWITCH_ENABLE = 1'b1;
      repeat (4) @(posedge CLK);
      RST_N <= 1'b1;
      tick(3);
      // reset values, read-only and unmapped places
      rc(A_FLT, status_bank_pkg::RST_FAULT, 8'hff);
      rc(A_FLT, 8'h00, 8'hff);
      rc(A_EVT, status_bank_pkg::RST_EVENT, 8'hff);
      rc(A_PRI, status_bank_pkg::RST_PROF, 8'hff);
      rc(A_LEG, status_bank_pkg::RST_PROF, 8'hff);
      rc(A_MISC, 8'h00, 8'hff);
      rc(A_PIN, {2'h0, 4'ha, status_bank_pkg::CODE_ACTIVE}, 8'h3f);
      rc(8'h20, 8'h00, 8'hff);
      wr(A_FLT, 8'h80);
      rc(A_FLT, 8'h00, 8'hff);
      wr(A_EVT, 8'hff);
      rc(A_EVT, 8'h00, 8'hff);
      // sleep is never reported on a read
      @(posedge CLK) {SLEEP_REQ, SWITCH_ENABLE} <= 2'b10;
      tick(3);
      check8({6'h0, POWER_STATE_CODE}, {6'h0, status_bank_pkg::CODE_SLEEP});
      rc(A_PIN, {6'h0, status_bank_pkg::CODE_DETECT}, 8'h03);
      @(posedge CLK) {SLEEP_REQ, SWITCH_ENABLE} <= 2'b01;
      // line mirrors, draw flag, emulation and step
      @(posedge CLK) {ext_alert_low, ext_det_low, DRAW_ABOVE, EMU_APPLYING, HANDSHAKE_STEP} <= 6'h3e;
      tick(5);
      rc(A_MISC, 8'h3e, 8'h3f);
      @(posedge CLK) {ext_alert_low, ext_det_low, DRAW_ABOVE, EMU_APPLYING, HANDSHAKE_STEP} <= 6'h00;
      tick(5);
      rc(A_MISC, 8'h00, 8'h3f);
      // attach, read clear, event during read
      @(posedge CLK) ATTACH_EVT <= 1'b1;
      @(posedge CLK) ATTACH_EVT <= 1'b0;
      tick(2);
      check1(DET_OE, 1'b1);
      check1(ALERT_OE, 1'b0);
      rc(A_MISC, 8'h10, 8'h30);
      rc(A_EVT, 8'h01, 8'h03);
      rc(A_EVT, 8'h00, 8'h03);
      @(posedge CLK);
      RD_EN <= 1'b1;
      ADDR <= A_EVT;
      ATTACH_EVT <= 1'b1;
      @(posedge CLK);
      RD_EN <= 1'b0;
      ATTACH_EVT <= 1'b0;
      rc(A_EVT, 8'h01, 8'h01);
      // profile bits and removal
      @(posedge CLK) {PROF_PRI_SET, PROF_LEG_SET, VS_LOW} <= {5'h01, 7'h40, 1'b1};
      @(posedge CLK) {PROF_PRI_SET, PROF_LEG_SET} <= '0;
      tick(4);
      rc(A_PRI, 8'h11, 8'h1f);
      rc(A_LEG, 8'h40, 8'h7f);
      @(posedge CLK) REMOVAL_EVT <= 1'b1;
      @(posedge CLK) REMOVAL_EVT <= 1'b0;
      tick(2);
      check1(DET_OE, 1'b0);
      check1(ALERT_OE, 1'b0);
      rc(A_EVT, 8'h02, 8'h03);
      rc(A_PRI, 8'h10, 8'h1f);
      rc(A_LEG, 8'h00, 8'h7f);
      @(posedge CLK) PROF_LEG_SET <= 7'h01;
      @(posedge CLK) {PROF_LEG_SET, NEW_MODE} <= {7'h00, 1'b1};
      @(posedge CLK) NEW_MODE <= 1'b0;
      rc(A_LEG, 8'h00, 8'h7f);
      // throttle and small draw, fault line link
      @(posedge CLK) THROTTLE_COND <= 1'b1;
      tick(5);
      check1(ALERT_OE, 1'b0);
      rc(A_EVT, 8'h08, 8'h08);
      @(posedge CLK) {THROTTLE_COND, ALERT_LINK, SMALL_COND} <= 3'b011;
      tick(5);
      check1(ALERT_OE, 1'b1);
      rc(A_FLT, 8'h00, 8'h80);
      rc(A_EVT, 8'h04, 8'h04);
      @(posedge CLK) {ALERT_LINK, SMALL_COND} <= 2'b00;
      tick(5);
      rd(A_EVT, d);
      rc(A_EVT, 8'h00, 8'h0c);
      // clamp flag is live
      @(posedge CLK) CLAMP_COND <= 1'b1;
      tick(5);
      rc(A_EVT, 8'h10, 8'h10);
      rc(A_EVT, 8'h10, 8'h10);
      @(posedge CLK) CLAMP_COND <= 1'b0;
      tick(5);
      rc(A_EVT, 8'h00, 8'h10);
      // charge quota: set, restart, disable
      @(posedge CLK) {QUOTA_ENABLE, QUOTA_ACTION_SELECT, QUOTA_MET} <= 3'b111;
      @(posedge CLK) QUOTA_MET <= 1'b0;
      tick(2);
      check1(ALERT_OE, 1'b1);
      rc(A_EVT, 8'h80, 8'h80);
      rc(A_EVT, 8'h00, 8'h80);
      @(posedge CLK) QUOTA_MET <= 1'b1;
      @(posedge CLK) {QUOTA_MET, QUOTA_RESTART} <= 2'b01;
      @(posedge CLK) QUOTA_RESTART <= 1'b0;
      rc(A_EVT, 8'h00, 8'h80);
      @(posedge CLK) QUOTA_MET <= 1'b1;
      @(posedge CLK) {QUOTA_MET, QUOTA_ENABLE} <= 2'b00;
      tick(1);
      rc(A_EVT, 8'h00, 8'h80);
      // each latched fault, read clear, error clear by write
      for (int i = 0; i < 6; i++)
      begin
         @(posedge CLK) FAULT_COND <= 6'h01 << i;
         tick(5);
         check1(ALERT_OE, 1'b1);
         check8({6'h0, POWER_STATE_CODE}, {6'h0, status_bank_pkg::CODE_ERROR});
         rc(A_FLT, 8'h80 | fmap[i], 8'hff);
         @(posedge CLK) FAULT_COND <= 6'h00;
         tick(5);
         rc(A_FLT, 8'h80 | fmap[i], 8'hff);
         rc(A_FLT, 8'h80, 8'hff);
         wr(A_FLT, 8'h00);
         tick(3);
         check1(POWER_STATE_CODE == status_bank_pkg::CODE_ERROR, 1'b0);
         rc(A_FLT, 8'h00, 8'hff);
      end
      // auto-recovery clears error flag and fault flags
      @(posedge CLK) {AUTO_RECOVERY, FAULT_COND} <= 7'h41;
      tick(5);
      rc(A_FLT, 8'h81, 8'hff);
      @(posedge CLK) FAULT_COND <= 6'h00;
      tick(5);
      rc(A_FLT, 8'h00, 8'hff);
      check8({6'h0, POWER_STATE_CODE}, {6'h0, status_bank_pkg::CODE_ACTIVE});
      // switch off clears the error flag
      @(posedge CLK) {AUTO_RECOVERY, FAULT_COND} <= 7'h04;
      tick(5);
      @(posedge CLK) {FAULT_COND, SWITCH_ENABLE} <= 7'h00;
      tick(5);
      rc(A_FLT, 8'h00, 8'h80);
      @(posedge CLK) SWITCH_ENABLE <= 1'b1;
      tick(3);
      summarize();
   end
endmodule
